// >>> verilog/mpg_pkg.sv
package mpg_pkg;
  // register offsets (flat 8-bit address, page folded into the offset)
  localparam logic [7:0] ADDR_ADC_GAIN_FLAGS   = 8'h24;
  localparam logic [7:0] ADDR_MIC_BIAS_SELECT  = 8'h2E;
  localparam logic [7:0] ADDR_MIC_PREAMP_GAIN  = 8'h2F;
  localparam logic [7:0] ADDR_POS_INPUT_RES    = 8'h30;
  localparam logic [7:0] ADDR_NEG_INPUT_RES    = 8'h31;
  localparam logic [7:0] ADDR_ADC_POWER_SSTEP  = 8'h51;
  localparam logic [7:0] ADDR_ADC_MUTE_CONTROL = 8'h52;
  localparam logic [7:0] ADDR_AUTO_GAIN_CTRL   = 8'h56;

  // reset values
  localparam logic [7:0] RST_MIC_BIAS_SELECT  = 8'h00;
  localparam logic [7:0] RST_MIC_PREAMP_GAIN  = 8'h00;
  localparam logic [7:0] RST_POS_INPUT_RES    = 8'h00;
  localparam logic [7:0] RST_NEG_INPUT_RES    = 8'h00;
  localparam logic [7:0] RST_ADC_POWER_SSTEP  = 8'h00;
  localparam logic [7:0] RST_ADC_MUTE_CONTROL = 8'h00;
  localparam logic [7:0] RST_AUTO_GAIN_CTRL   = 8'h00;

  // field positions
  localparam int BIT_GAIN_REACHED = 7;
  localparam int BIT_ADC_POWERED  = 6;
  localparam int BIT_PREAMP_EN    = 7;
  localparam int BIT_ADC_PWR_UP   = 7;
  localparam int BIT_ADC_MUTE     = 7;
  localparam int BIT_AGC_EN       = 7;
  localparam int POS_RES_HI       = 7;
  localparam int POS_RES_LO       = 6;

  // soft-step modes in the power register, bits 1..0
  localparam logic [1:0] SSTEP_EVERY_TICK  = 2'h0;
  localparam logic [1:0] SSTEP_EVERY_OTHER = 2'h1;

  // bias levels
  localparam logic [1:0] BIAS_OFF   = 2'h0;
  localparam logic [1:0] BIAS_2V0   = 2'h1;
  localparam logic [1:0] BIAS_2V5   = 2'h2;
  localparam logic [1:0] BIAS_SUPPLY = 2'h3;

  // resistance codes and gain offsets in 0.5 dB units
  localparam logic [1:0]        RES_PLUS6      = 2'h1;
  localparam logic signed [8:0] OFS_PLUS6DB    = 9'sh00C;
  localparam logic signed [8:0] OFS_MINUS6DB   = -9'sh00C;
  localparam logic signed [8:0] OFS_NONE       = 9'sh000;
  localparam logic signed [8:0] OFS_DIFF_6DB   = 9'sh00C;

  localparam logic [6:0] GAIN_MAX_CODE = 7'h77;
  localparam logic [6:0] GAIN_ZERO     = 7'h00;

  // soft-step tick from the internal oscillator divider
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int STEP_PERIOD_PS  = 1000000;
  localparam int STEP_CYC        = (STEP_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [8:0] STEP_CNT_LAST = 9'(STEP_CYC - 1);

  typedef enum logic [1:0] {
    MPG_PWR_OFF  = 2'b00,
    MPG_PWR_ON   = 2'b01,
    MPG_PWR_RAMP = 2'b11
  } mpg_pwr_t;
endpackage

// >>> verilog/mpg_step_timer.sv
`timescale 1ns/100ps
// free-running divider standing in for the internal oscillator; it counts core_clk_i,
// so the ramp rate scales with that clock (one tick every 250 cycles)
module mpg_step_timer (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [8:0] count;
  wire        wrap = (count == mpg_pkg::STEP_CNT_LAST);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count  <= 9'h000;
      tick_o <= 1'b0;
    end else begin
      count  <= wrap ? 9'h000 : count + 9'h001;
      tick_o <= wrap;
    end
  end
endmodule

// >>> verilog/mpg_gain_ctrl.sv
`timescale 1ns/100ps
// Function
// RULE_01 - two-bit bias field: off, 2 V, 2.5 V, analog supply level
// RULE_02 - seven-bit gain code, 0 to 59.5 dB in 0.5 dB steps
// RULE_03 - new gain is reached by soft-stepping, never applied at once; with power register bits 1..0 at 1x the code jumps straight to it
// RULE_04 - after reset gain is muted and soft-stepping is enabled
// RULE_05 - two-bit field in ADC power register enables or disables soft-stepping
// RULE_06 - step timing comes from an internal divider, not codec clock; the divider here counts core_clk_i
// RULE_07 - positive-left resistance from bits 7..6, others from bits 5..2
// RULE_08 - resistance code 01 adds 6 dB, codes 10 and 11 subtract 6 dB
// RULE_09 - differential input adds 6 dB more to effective gain
// RULE_10 - auto gain enable selects loop gain, else the fixed field
// RULE_11 - read-only flag set while applied gain equals requested gain
// RULE_12 - top gain bit enables preamp; disabled preamp gain is 0 dB
// RULE_13 - ADC mute freezes the digital record output value
// RULE_14 - host keeps codec clock running past the ADC power-down write
// RULE_15 - host stops codec clock only after powered flag clears
// RULE_16 - power register top bit powers ADC; flag bit six reports it
// RULE_17 - all registers eight bits; writable ones read back
// RULE_18 - a write during stepping retargets; flag clear until reached
// RULE_19 - each step moves one code and stops at the target
module mpg_gain_ctrl (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic [6:0]  agc_gain_i,
  input  wire logic [15:0] adc_sample_i,
  input  wire logic        adc_sample_valid_i,
  output logic      [7:0]  reg_rdata_o,
  output logic      [1:0]  mic_bias_out_o,
  output logic             preamp_en_o,
  output logic      [6:0]  applied_gain_o,
  output logic             gain_muted_o,
  output logic signed [8:0] eff_gain_o,
  output logic      [3:0]  other_input_resistance_o,
  output logic             adc_powered_o,
  output logic      [15:0] adc_out_o
);
  logic [7:0] bias_reg;
  logic [7:0] gain_reg;
  logic [7:0] pos_res_reg;
  logic [7:0] neg_res_reg;
  logic [7:0] pwr_reg;
  logic [7:0] mute_reg;
  logic [7:0] agc_reg;
  logic       gain_reached;
  logic       step_phase;
  mpg_pkg::mpg_pwr_t pwr_state;
  mpg_pkg::mpg_pwr_t next_pwr_state;
  logic       tick;

  mpg_step_timer u_step_timer (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .tick_o     (tick)
  );

  // write decode
  wire wr_bias = reg_wr_i && (reg_addr_i == mpg_pkg::ADDR_MIC_BIAS_SELECT);
  wire wr_gain = reg_wr_i && (reg_addr_i == mpg_pkg::ADDR_MIC_PREAMP_GAIN);
  wire wr_pos  = reg_wr_i && (reg_addr_i == mpg_pkg::ADDR_POS_INPUT_RES);
  wire wr_neg  = reg_wr_i && (reg_addr_i == mpg_pkg::ADDR_NEG_INPUT_RES);
  wire wr_pwr  = reg_wr_i && (reg_addr_i == mpg_pkg::ADDR_ADC_POWER_SSTEP);
  wire wr_mute = reg_wr_i && (reg_addr_i == mpg_pkg::ADDR_ADC_MUTE_CONTROL);
  wire wr_agc  = reg_wr_i && (reg_addr_i == mpg_pkg::ADDR_AUTO_GAIN_CTRL);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bias_reg    <= mpg_pkg::RST_MIC_BIAS_SELECT;
      gain_reg    <= mpg_pkg::RST_MIC_PREAMP_GAIN;
      pos_res_reg <= mpg_pkg::RST_POS_INPUT_RES;
      neg_res_reg <= mpg_pkg::RST_NEG_INPUT_RES;
      pwr_reg     <= mpg_pkg::RST_ADC_POWER_SSTEP;
      mute_reg    <= mpg_pkg::RST_ADC_MUTE_CONTROL;
      agc_reg     <= mpg_pkg::RST_AUTO_GAIN_CTRL;
    end else begin
      if (wr_bias) bias_reg    <= reg_wdata_i; // [RULE_17]
      if (wr_gain) gain_reg    <= reg_wdata_i; // [RULE_17]
      if (wr_pos)  pos_res_reg <= reg_wdata_i;
      if (wr_neg)  neg_res_reg <= reg_wdata_i;
      if (wr_pwr)  pwr_reg     <= reg_wdata_i;
      if (wr_mute) mute_reg    <= reg_wdata_i;
      if (wr_agc)  agc_reg     <= reg_wdata_i;
    end
  end

  // read mux; unmapped addresses read zero
  wire [7:0] flags_val = {gain_reached, adc_powered_o, 6'h00}; // [RULE_11] [RULE_16]
  wire [7:0] rd_val =
    (reg_addr_i == mpg_pkg::ADDR_ADC_GAIN_FLAGS)   ? flags_val   :
    (reg_addr_i == mpg_pkg::ADDR_MIC_BIAS_SELECT)  ? bias_reg    :
    (reg_addr_i == mpg_pkg::ADDR_MIC_PREAMP_GAIN)  ? gain_reg    :
    (reg_addr_i == mpg_pkg::ADDR_POS_INPUT_RES)    ? pos_res_reg :
    (reg_addr_i == mpg_pkg::ADDR_NEG_INPUT_RES)    ? neg_res_reg :
    (reg_addr_i == mpg_pkg::ADDR_ADC_POWER_SSTEP)  ? pwr_reg     :
    (reg_addr_i == mpg_pkg::ADDR_ADC_MUTE_CONTROL) ? mute_reg    :
    (reg_addr_i == mpg_pkg::ADDR_AUTO_GAIN_CTRL)   ? agc_reg     : 8'h00;

  // gain target selection
  wire       pga_on    = gain_reg[mpg_pkg::BIT_PREAMP_EN];
  wire       agc_on    = agc_reg[mpg_pkg::BIT_AGC_EN];
  wire       pwr_req   = pwr_reg[mpg_pkg::BIT_ADC_PWR_UP];
  wire [6:0] req_gain  = agc_on ? agc_gain_i : gain_reg[6:0]; // [RULE_10]
  wire [6:0] req_clip  = (req_gain > mpg_pkg::GAIN_MAX_CODE) ? mpg_pkg::GAIN_MAX_CODE
                                                             : req_gain; // [RULE_02]
  // disabled preamp and a ramp to power-down both aim at 0 dB
  wire       aim_zero  = !pga_on || (pwr_state == mpg_pkg::MPG_PWR_RAMP);
  wire [6:0] target    = aim_zero ? mpg_pkg::GAIN_ZERO : req_clip; // [RULE_12]

  // soft-step control: mode 00 every tick, 01 every other tick, 1x jumps
  wire [1:0] sstep_mode = pwr_reg[1:0];
  wire       sstep_on   = (sstep_mode == mpg_pkg::SSTEP_EVERY_TICK) ||
                          (sstep_mode == mpg_pkg::SSTEP_EVERY_OTHER); // [RULE_05]
  wire       step_due   = tick && ((sstep_mode == mpg_pkg::SSTEP_EVERY_TICK) || step_phase); // [RULE_06]
  wire       at_target  = (applied_gain_o == target);
  wire       go_up      = applied_gain_o < target;
  wire [6:0] step_gain  = go_up ? applied_gain_o + 7'h01 : applied_gain_o - 7'h01; // [RULE_19]
  wire [6:0] next_gain  = at_target ? applied_gain_o :
                          !sstep_on ? target :
                          step_due  ? step_gain : applied_gain_o; // [RULE_03] [RULE_18]

  // power sequencing
  always_comb begin
    next_pwr_state = pwr_state;
    unique case (pwr_state)
      mpg_pkg::MPG_PWR_OFF:  if (pwr_req) next_pwr_state = mpg_pkg::MPG_PWR_ON;
      mpg_pkg::MPG_PWR_ON:   if (!pwr_req) next_pwr_state = mpg_pkg::MPG_PWR_RAMP;
      mpg_pkg::MPG_PWR_RAMP: begin
        if (pwr_req) next_pwr_state = mpg_pkg::MPG_PWR_ON;
        else if (applied_gain_o == mpg_pkg::GAIN_ZERO) next_pwr_state = mpg_pkg::MPG_PWR_OFF;
      end
      default: next_pwr_state = mpg_pkg::MPG_PWR_OFF;
    endcase
  end

  // effective gain including resistance and differential offsets
  wire [1:0] pos_res = pos_res_reg[mpg_pkg::POS_RES_HI:mpg_pkg::POS_RES_LO]; // [RULE_07]
  wire signed [8:0] res_ofs = (pos_res == 2'h0) ? mpg_pkg::OFS_NONE :
                              (pos_res == mpg_pkg::RES_PLUS6) ? mpg_pkg::OFS_PLUS6DB
                                                              : mpg_pkg::OFS_MINUS6DB; // [RULE_08]
  wire       diff_in  = (neg_res_reg[mpg_pkg::POS_RES_HI:mpg_pkg::POS_RES_LO] != 2'h0);
  wire signed [8:0] diff_ofs = diff_in ? mpg_pkg::OFS_DIFF_6DB : mpg_pkg::OFS_NONE; // [RULE_09]
  wire signed [8:0] next_eff = $signed({2'b00, next_gain}) + res_ofs + diff_ofs;

  wire next_muted = !pga_on || (next_pwr_state == mpg_pkg::MPG_PWR_OFF);
  wire take_sample = adc_sample_valid_i && adc_powered_o && !mute_reg[mpg_pkg::BIT_ADC_MUTE];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_state                <= mpg_pkg::MPG_PWR_OFF;
      applied_gain_o           <= mpg_pkg::GAIN_ZERO;
      gain_muted_o             <= 1'b1; // [RULE_04]
      step_phase               <= 1'b0;
      gain_reached             <= 1'b1;
      eff_gain_o               <= mpg_pkg::OFS_NONE;
      reg_rdata_o              <= 8'h00;
      mic_bias_out_o           <= mpg_pkg::BIAS_OFF;
      preamp_en_o              <= 1'b0;
      other_input_resistance_o <= 4'h0;
      adc_powered_o            <= 1'b0;
      adc_out_o                <= 16'h0000;
    end else begin
      pwr_state      <= next_pwr_state;
      applied_gain_o <= next_gain;
      gain_muted_o   <= next_muted;
      if (tick) step_phase <= !step_phase;
      gain_reached   <= (next_gain == target); // [RULE_11] [RULE_18]
      eff_gain_o     <= next_eff;
      if (reg_rd_i) reg_rdata_o <= rd_val;
      mic_bias_out_o <= bias_reg[1:0]; // [RULE_01]
      preamp_en_o    <= pga_on; // [RULE_12]
      other_input_resistance_o <= pos_res_reg[5:2]; // [RULE_07]
      adc_powered_o  <= (next_pwr_state != mpg_pkg::MPG_PWR_OFF); // [RULE_16]
      if (take_sample) adc_out_o <= adc_sample_i; // [RULE_13]
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pwr_drop;
    (pwr_state == mpg_pkg::MPG_PWR_ON) && !pwr_req;
  endsequence

  a_gain_single_step: assert property ( // [RULE_19]
    sstep_on |=> (applied_gain_o == $past(applied_gain_o)) ||
                 (applied_gain_o == $past(applied_gain_o) + 7'h01) ||
                 (applied_gain_o == $past(applied_gain_o) - 7'h01))
    else $error("applied gain moved more than one code");
  a_step_on_tick: assert property ( // [RULE_06]
    (sstep_on && !step_due && !at_target) |=> applied_gain_o == $past(applied_gain_o))
    else $error("gain stepped without a divider tick");
  a_flag_matches: assert property ( // [RULE_11]
    gain_reached == (applied_gain_o == $past(target)))
    else $error("gain reached flag does not match applied gain");
  a_pga_off_zero: assert property ( // [RULE_12]
    (!pga_on && !sstep_on) |=> applied_gain_o == mpg_pkg::GAIN_ZERO)
    else $error("disabled preamp gain not 0 dB");
  a_mute_holds: assert property ( // [RULE_13]
    mute_reg[mpg_pkg::BIT_ADC_MUTE] |=> $stable(adc_out_o))
    else $error("record output changed while muted");
  a_ramp_before_off: assert property ( // [RULE_16]
    s_pwr_drop ##1 (applied_gain_o != mpg_pkg::GAIN_ZERO) |-> adc_powered_o)
    else $error("powered flag cleared before ramp to zero");
  a_jump_no_sstep: assert property ( // [RULE_05]
    (!sstep_on && !wr_pwr) |=> applied_gain_o == $past(target))
    else $error("gain did not jump with soft-stepping off");
  a_pos_offset: assert property ( // [RULE_08]
    (pos_res == mpg_pkg::RES_PLUS6 && !diff_in) |=>
      eff_gain_o == $signed({2'b00, applied_gain_o}) + mpg_pkg::OFS_PLUS6DB)
    else $error("resistance code 01 offset wrong");
  a_bias_follow: assert property ( // [RULE_01]
    wr_bias |=> ##1 mic_bias_out_o == $past(reg_wdata_i[1:0], 2))
    else $error("bias output not following register");
  a_reset_mute: assert property ( // [RULE_04]
    $fell(rst_i) |-> gain_muted_o)
    else $error("gain not muted after reset");

  // every output is a flop, so each check below but a_gain_in_range ties an output to the
  // decode of the edge before; a miss points at the decode, not the port
  sequence s_ramp_due;
    (pwr_state == mpg_pkg::MPG_PWR_RAMP) && !pwr_req && sstep_on && step_due &&
      (applied_gain_o != mpg_pkg::GAIN_ZERO);
  endsequence

  sequence s_jump_agc;
    agc_on && !aim_zero && !sstep_on && (agc_gain_i <= mpg_pkg::GAIN_MAX_CODE);
  endsequence

  sequence s_jump_fixed;
    !agc_on && !aim_zero && !sstep_on && (gain_reg[6:0] <= mpg_pkg::GAIN_MAX_CODE);
  endsequence

  a_gain_in_range: assert property ( // [RULE_02]
    applied_gain_o <= mpg_pkg::GAIN_MAX_CODE)
    else $error("applied gain above the top code");

  a_clip_high: assert property ( // [RULE_02]
    (req_gain > mpg_pkg::GAIN_MAX_CODE && !aim_zero && !sstep_on) |=>
      applied_gain_o == mpg_pkg::GAIN_MAX_CODE)
    else $error("gain code above range not clipped");

  // this ramp is why the host must keep the codec clock alive after power-down
  a_ramp_step_down: assert property ( // [RULE_03]
    s_ramp_due |=>
      applied_gain_o == $past(applied_gain_o) - 7'h01)
    else $error("ramp to power-down did not step down");

  a_reached_holds: assert property ( // [RULE_11]
    at_target |=>
      gain_reached)
    else $error("gain reached flag clear at target");

  a_flag_clear_moving: assert property ( // [RULE_18]
    (next_gain != target) |=>
      !gain_reached)
    else $error("gain reached flag set while stepping");

  a_preamp_follow: assert property ( // [RULE_12]
    1'b1 |=>
      preamp_en_o == $past(pga_on))
    else $error("preamp enable not following gain register");

  a_disable_mutes: assert property ( // [RULE_12]
    !pga_on |=>
      gain_muted_o)
    else $error("disabled preamp not muted");

  a_sample_capture: assert property ( // [RULE_13]
    take_sample |=>
      adc_out_o == $past(adc_sample_i))
    else $error("record sample not captured");

  a_unpowered_hold: assert property ( // [RULE_13]
    !adc_powered_o |=>
      $stable(adc_out_o))
    else $error("record output changed while powered down");

  a_power_up: assert property ( // [RULE_16]
    (pwr_state == mpg_pkg::MPG_PWR_OFF && pwr_req) |=>
      adc_powered_o)
    else $error("ADC did not report powered up");

  a_stay_off: assert property ( // [RULE_16]
    (pwr_state == mpg_pkg::MPG_PWR_OFF && !pwr_req) |=>
      !adc_powered_o)
    else $error("ADC reported powered while off");

  a_off_at_zero: assert property ( // [RULE_16]
    (pwr_state == mpg_pkg::MPG_PWR_RAMP && !pwr_req &&
     applied_gain_o == mpg_pkg::GAIN_ZERO) |=>
      !adc_powered_o)
    else $error("powered flag still set after ramp reached zero");

  a_other_res: assert property ( // [RULE_07]
    1'b1 |=>
      other_input_resistance_o == $past(pos_res_reg[5:2]))
    else $error("other input resistance not following register");

  a_agc_select: assert property ( // [RULE_10]
    s_jump_agc |=>
      applied_gain_o == $past(agc_gain_i))
    else $error("automatic gain not applied");

  a_fixed_select: assert property ( // [RULE_10]
    s_jump_fixed |=>
      applied_gain_o == $past(gain_reg[6:0]))
    else $error("fixed gain not applied");

  a_diff_offset: assert property ( // [RULE_09]
    (pos_res == 2'h0 && diff_in) |=>
      eff_gain_o == $signed({2'b00, applied_gain_o}) + mpg_pkg::OFS_DIFF_6DB)
    else $error("differential offset wrong");

  a_minus_offset: assert property ( // [RULE_08]
    (pos_res[1] && !diff_in) |=>
      eff_gain_o == $signed({2'b00, applied_gain_o}) + mpg_pkg::OFS_MINUS6DB)
    else $error("resistance codes 10 and 11 offset wrong");
endmodule

// >>> verification/mpg_host_model.sv
`timescale 1ns/100ps
// host side of the register port; released lines carry the inverse so stale values never pass
module mpg_host_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'hA5;
    wdata_o = 8'h5A;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge core_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge core_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge core_clk_i);
    #1;
    d = rdata_i;
  endtask
  // codec clock stays up past the power-down write, stopped only once the flag clears
  task automatic power_down(output logic ok);
    logic [7:0] f;
    wr(8'h51, 8'h00);
    ok = 1'b0;
    for (int n = 0; n < 1000 && !ok; n++) begin
      rd(8'h24, f);
      ok = (f[6] === 1'b0);
    end
  endtask
endmodule

// >>> verification/mic_pga_gain_control_test.sv
`timescale 1ns/100ps
module mic_pga_gain_control_test;
  logic              core_clk_i, rst_i, wr, rd, vld, step_chk, pen, muted, pwr, ok;
  logic       [7:0]  addr, wdata, rdata, f, d;
  logic       [6:0]  agc, gain, prev_g;
  logic       [15:0] smp, dout, exp_q[$];
  logic       [1:0]  bias;
  logic signed [8:0] eff;
  logic       [3:0]  oth;
  int                n_errors, check_count, i, mirror[int];
  int                a_list[$] = '{'h2E, 'h2F, 'h30, 'h31, 'h51, 'h52, 'h56};

  mpg_host_model u_host (.core_clk_i(core_clk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));
  mpg_gain_ctrl dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .agc_gain_i(agc), .adc_sample_i(smp),
    .adc_sample_valid_i(vld), .reg_rdata_o(rdata), .mic_bias_out_o(bias), .preamp_en_o(pen),
    .applied_gain_o(gain), .gain_muted_o(muted), .eff_gain_o(eff),
    .other_input_resistance_o(oth), .adc_powered_o(pwr), .adc_out_o(dout));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    mirror[a] = v;
    u_host.wr(a, v);
  endtask
  task automatic wait_gain(input logic [6:0] g, input int lim);
    for (int n = 0; n < lim && gain !== g; n++) begin
      @(posedge core_clk_i);
    end
    #1;
    chk(16'(gain), 16'(g));
  endtask
  // expected effective gain in half-dB units from the mirrored resistance registers
  function automatic int eff_exp(int g);
    int e;
    e = g;
    if ((mirror['h30] >> 6) == 1) e += 12;
    else if ((mirror['h30] >> 6) > 1) e -= 12;
    if ((mirror['h31] >> 6) != 0) e += 12;
    return e;
  endfunction

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // whole sequence needs about 8k cycles; 50k leaves ample margin
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  always @(negedge core_clk_i) begin
    if (step_chk && gain !== prev_g)
      chk_flag((gain > prev_g ? gain - prev_g : prev_g - gain) == 7'd1, 1'b1);
    prev_g <= gain;
  end

  initial begin
    i = $urandom(32'h6125CFA3);
    rst_i = 1'b1;
    step_chk = 1'b0;
    agc = 7'h00;
    smp = 16'h0000;
    vld = 1'b0;
    foreach (a_list[k]) mirror[a_list[k]] = 0;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    chk_flag(muted, 1'b1);
    chk(16'(gain), 16'h0000);
    foreach (a_list[k]) begin
      u_host.rd(8'(a_list[k]), f);
      chk(16'(f), 16'(mirror[a_list[k]]));
      d = 8'($urandom);
      wreg(8'(a_list[k]), d);
      u_host.rd(8'(a_list[k]), f);
      chk(16'(f), 16'(d));
      wreg(8'(a_list[k]), 8'h00);
    end
    u_host.wr(8'h24, 8'hFF);
    u_host.rd(8'h40, f);
    chk(16'(f), 16'h0000);
    for (i = 0; i < 4; i++) begin
      wreg(8'h2E, 8'(i));
      wreg(8'h30, 8'($urandom) & 8'h3C);
      repeat (2) @(negedge core_clk_i);
      chk(16'(bias), 16'(i));
      chk(16'(oth), 16'(mirror['h30] >> 2));
    end
    wreg(8'h30, 8'h00);
    repeat (2000) @(posedge core_clk_i);
    $display("done: registers");
    wreg(8'h51, 8'h80);
    u_host.rd(8'h24, f);
    chk_flag(pwr, 1'b1);
    chk_flag(f[6], 1'b1);
    step_chk = 1'b1;
    wreg(8'h2F, 8'h84);
    repeat (10) @(negedge core_clk_i);
    chk_flag(gain <= 7'd1, 1'b1);
    u_host.rd(8'h24, f);
    chk_flag(f[7], 1'b0);
    wreg(8'h2F, 8'h86);
    wait_gain(7'h06, 2500);
    u_host.rd(8'h24, f);
    chk_flag(f[7], 1'b1);
    chk_flag(pen, 1'b1);
    for (i = 0; i < 4; i++) begin
      wreg(8'h30, 8'(i << 6));
      wreg(8'h31, i[0] ? 8'h00 : 8'hC0);
      repeat (3) @(negedge core_clk_i);
      chk(16'(eff), 16'(eff_exp(6)));
    end
    wreg(8'h30, 8'h00);
    wreg(8'h31, 8'h00);
    $display("done: soft step");
    step_chk = 1'b0;
    wreg(8'h51, 8'h82);
    wreg(8'h2F, 8'h90);
    wait_gain(7'h10, 20);
    agc <= 7'($urandom_range(32'h77, 32'h11));
    wreg(8'h56, 8'h80);
    wait_gain(agc, 20);
    @(posedge core_clk_i);
    agc <= 7'h7F;
    wait_gain(7'h77, 20);
    wreg(8'h56, 8'h00);
    wait_gain(7'h10, 20);
    wreg(8'h51, 8'h81);
    wreg(8'h2F, 8'h92);
    wait_gain(7'h11, 600);
    repeat (400) @(negedge core_clk_i);
    chk(16'(gain), 16'h0011);
    wait_gain(7'h12, 200);
    wreg(8'h51, 8'h82);
    for (i = 0; i < 4; i++) begin
      if (i == 2) wreg(8'h52, 8'h80);
      @(posedge core_clk_i);
      smp <= 16'($urandom);
      vld <= 1'b1;
      @(posedge core_clk_i);
      vld <= 1'b0;
      if (i < 2) exp_q.push_back(smp);
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk(dout, exp_q[$]);
    end
    wreg(8'h52, 8'h00);
    wreg(8'h2F, 8'h10);
    wait_gain(7'h00, 20);
    chk_flag(muted, 1'b1);
    $display("done: auto gain, mute, disable");
    wreg(8'h51, 8'h80);
    wreg(8'h2F, 8'h86);
    wait_gain(7'h06, 2500);
    u_host.power_down(ok);
    chk_flag(ok, 1'b1);
    chk(16'(gain), 16'h0000);
    $display("done: power down");
    end_of_test();
  end
endmodule
